/* File: dv/mic_core_model.sv */
// Purpose: core side of the controller: pc, return stack, acceptance readiness
// Assumes: one clock, synchronous active-low reset
// Notes:   slow mode drops readiness every other cycle
`timescale 1ns/100ps
`default_nettype none
module mic_core_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        slow,
	input  wire logic        pop_req,
	input  wire logic        irq_take,
	input  wire logic [15:0] irq_vector,
	output logic [15:0]      next_pc,
	output logic             irq_ack_ready,
	output logic             ret_pop
);
	logic [15:0] stk_q [$];
	logic        tick_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			next_pc       <= 16'h0100;
			ret_pop       <= 1'b0;
			irq_ack_ready <= 1'b0;
			tick_q        <= 1'b0;
			stk_q.delete();
		end else begin
			tick_q        <= !tick_q;
			irq_ack_ready <= !slow || tick_q;
			ret_pop       <= pop_req && stk_q.size() > 0;
			if (irq_take) begin
				stk_q.push_back(next_pc);
				next_pc <= irq_vector;
			end else if (pop_req && stk_q.size() > 0) begin
				next_pc <= stk_q.pop_back();
			end
		end
	end
endmodule : mic_core_model
`default_nettype wire

/* File: dv/mic_intc_monitor.sv */
// Purpose: port checker of the interrupt controller
// Assumes: clk_en held high
// Notes:   bound to every controller instance
`timescale 1ns/100ps
`default_nettype none
module mic_intc_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [3:0]  pull_high_sel,
	input wire logic [3:0]  pull_high_en,
	input wire logic        ret_pop,
	input wire logic        irq_ack_ready,
	input wire logic        irq_take,
	input wire logic [15:0] irq_vector,
	input wire logic [3:0]  stack_ptr
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_PULL_HIGH: assert property (pull_high_en == pull_high_sel)
		else $error("pull-high enable differs");
	AST_TAKE_PULSE: assert property (irq_take |=> !irq_take [*3])
		else $error("take repeated too soon");
	AST_TAKE_ROOM: assert property (irq_take |-> $past(stack_ptr) < 4'h8)
		else $error("take with full stack");
	AST_PUSH: assert property (irq_take |-> stack_ptr == $past(stack_ptr) + 4'h1)
		else $error("stack pointer not pushed");
	AST_POP: assert property ((ret_pop && stack_ptr != 4'h0) |=>
		(irq_take || stack_ptr == $past(stack_ptr) - 4'h1))
		else $error("stack pointer not popped");
	AST_ACK_READY: assert property (irq_take |-> $past(irq_ack_ready, 2))
		else $error("take without core readiness");
	AST_VEC_HOLD: assert property (irq_take |=> $stable(irq_vector) [*2])
		else $error("vector not held");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	cover property (irq_take);
	cover property (ret_pop ##[1:20] irq_take);
	cover property (stack_ptr == 4'h8);
endmodule : mic_intc_monitor
bind mic_intc mic_intc_monitor i_mic_intc_monitor (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .pull_high_sel, .pull_high_en, .ret_pop,
	.irq_ack_ready, .irq_take, .irq_vector, .stack_ptr);
`default_nettype wire

/* File: dv/mic_intc_test.sv */
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model answers takes; clk_en held high
// Notes:   pin share and direction tied on
`timescale 1ns/100ps
`default_nettype none
module mic_intc_test;
	localparam logic [15:0] VCONV = 16'h0014;
	localparam logic [15:0] VGRP1 = 16'h001C;
	localparam logic [15:0] VPIN0 = 16'h0040;
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, pop_req = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [8:0]  ev = '0;
	logic [3:0]  ext_irq_pins = '0, pull_high_sel = 4'hA, pull_high_en, stack_ptr;
	logic [15:0] next_pc, irq_vector, irq_push_pc, exp_pc;
	logic        irq_ack_ready, ret_pop, irq_take, wake_req;
	int          failures = 0, checked = 0, cycles = 0;
	mic_intc #(.VEC_PIN0(VPIN0), .VEC_CONV(VCONV), .VEC_GRP1(VGRP1)) i_mic_intc (
		.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ct0_cmpa_evt(ev[0]),
		.ct0_period_evt(ev[1]), .ct1_cmpa_evt(ev[2]), .ct1_period_evt(ev[3]),
		.pt_cmpa_evt(ev[4]), .pt_period_evt(ev[5]), .eeprom_write_done_evt(ev[6]),
		.low_voltage_evt(ev[7]), .conv_done_evt(ev[8]), .ext_irq_pins,
		.pin_share_sel(4'hF), .port_dir_input(4'hF), .pull_high_sel, .pull_high_en,
		.next_pc, .ret_pop, .irq_ack_ready, .irq_take, .irq_vector, .irq_push_pc,
		.stack_ptr, .wake_req);
	mic_core_model i_mic_core_model (.aclk, .aresetn, .slow, .pop_req, .irq_take,
		.irq_vector, .next_pc, .irq_ack_ready, .ret_pop);
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// ----------------------------------------------------------------
	// bus, event and core helpers
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
	endtask : axi_wr
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk("read resp", (a > 32'h1C) ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
		chk("read data", exp, s_axi_rdata);
	endtask : rchk
	task automatic pulse(input logic [8:0] m);
		ev <= m;
		@(posedge aclk);
		ev <= 9'h000;
		@(posedge aclk);
	endtask : pulse
	task automatic no_take(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge aclk);
			seen = seen | irq_take;
		end
		chk("no take", 32'h0, {31'h0, seen});
	endtask : no_take
	task automatic wait_take(input logic [15:0] v);
		int n;
		n = 0;
		while (irq_take !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		chk("take", 32'h1, {31'h0, irq_take});
		chk("vector", {16'h0, v}, {16'h0, irq_vector});
		chk("push pc", {16'h0, exp_pc}, {16'h0, irq_push_pc});
	endtask : wait_take
	task automatic pop();
		pop_req <= 1'b1;
		@(posedge aclk);
		pop_req <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : pop
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			rchk(4 * i, 32'h0);
			axi_wr(4 * i, 32'hFFFFFFFF);
			rchk(4 * i, 32'h33);
			axi_wr(4 * i, 32'h0);
		end
		rchk(32'h14, 32'h0);
		rchk(32'h40, 32'h0);
		axi_wr(32'h14, 32'h1);
		for (int i = 0; i < 8; i++) begin
			pulse(9'h001 << i);
			chk("wake", 32'h1, {31'h0, wake_req});
			rchk(i / 2 * 4, (i % 2) ? 32'h10 : 32'h20);
			axi_wr(i / 2 * 4, 32'h0);
		end
		no_take(4);
		axi_wr(32'h14, 32'h0);
	endtask : t_regs
	task automatic t_group();
		axi_wr(32'h4, 32'h2);
		axi_wr(32'h14, 32'h401);
		exp_pc = 16'h0100;
		pulse(9'h004);
		wait_take(VGRP1);
		rchk(32'h14, 32'h400);
		rchk(32'h4, 32'h22);
		axi_wr(32'h4, 32'h0);
		pop();
	endtask : t_group
	task automatic t_pins();
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			axi_wr(32'h10, {30'h0, c});
			axi_wr(32'h14, 32'h2);
			ext_irq_pins <= 4'h1;
			repeat (3) @(posedge aclk);
			rchk(32'h14, {26'h0, c[0], 5'h02});
			axi_wr(32'h14, 32'h2);
			ext_irq_pins <= 4'h0;
			repeat (3) @(posedge aclk);
			rchk(32'h14, {26'h0, c[1], 5'h02});
		end
		axi_wr(32'h14, 32'h3);
		ext_irq_pins <= 4'h1;
		wait_take(VPIN0);
		rchk(32'h14, 32'h2);
		axi_wr(32'h10, 32'h0);
		ext_irq_pins <= 4'h0;
		pop();
	endtask : t_pins
	task automatic t_conv_stack();
		slow <= 1'b1;
		axi_wr(32'h14, 32'h8000);
		pulse(9'h100);
		no_take(10);
		rchk(32'h14, 32'hC000);
		for (int k = 0; k < 8; k++) begin
			axi_wr(32'h14, 32'hC001);
			wait_take(VCONV);
			exp_pc = VCONV;
			pulse(9'h100);
		end
		axi_wr(32'h14, 32'hC001);
		no_take(10);
		rchk(32'h18, 32'h4800);
		pop();
		wait_take(VCONV);
		rchk(32'h14, 32'h8000);
	endtask : t_conv_stack
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_group();
		t_pins();
		t_conv_stack();
		give_verdict();
	end
endmodule : mic_intc_test
`default_nettype wire

/* File: logic/mic_intc.sv */
// Contract
// - compact timer 0 register: cmp-A flag b5, period flag b4, enables b1, b0
// - compact timer 1 register uses same layout, all read-write
// - periodic timer register: cmp-A flag b5, period flag b4, enables b1, b0
// - eeprom/low-voltage register: eeprom flag b5, low-voltage b4, enables b1, b0
// - bits 7:6 and 3:2 read zero; implemented bits reset to zero
// - member and converter flags set on events even when disabled; disabled source never jumps
// - global enable zero suppresses every interrupt
// - acceptance pushes next pc and loads vector; return pops pc
// - servicing clears global enable automatically
// - requests during servicing stay latched and are served later
// - setting global enable inside a routine allows nesting
// - stack full blocks acknowledge until stack pointer decrements
// - any set flag raises the wake request
// - pin flags set on the selected edge of their pin
// - pin jumps need global, pin enable, edge mode nonzero, stack room
// - pin acts only when enabled, selected by pin-share and an input
// - pin service clears that pin flag and global enable
// - pull-high stays active while pin is an interrupt input
// - edge select gives rising, falling, both or disabled per pin
// - conversion done sets flag; jumps with global, enable, stack room
// - converter service clears its flag and global enable
// - own vectors and shared group vectors coexist
// - edge code 00 off, 01 rising, 10 falling, 11 both
// - group flag follows member flags, not cleared on service; members kept
// - global enable is bit 0 of primary control, reset zero
//
// Purpose: interrupt controller with group registers, pin edges and vector jump
// Assumes: core pulses ret_pop on the return instruction; inputs synchronous
// Notes:   vector order: pin0..3, converter, group0..3 (index 0..8)
`timescale 1ns/100ps
`default_nettype none
`include "mic_params.svh"

module mic_intc #(
	parameter logic [15:0] VEC_PIN0 = 16'h0004,
	parameter logic [15:0] VEC_PIN1 = 16'h0008,
	parameter logic [15:0] VEC_PIN2 = 16'h000C,
	parameter logic [15:0] VEC_PIN3 = 16'h0010,
	parameter logic [15:0] VEC_CONV = 16'h0014,
	parameter logic [15:0] VEC_GRP0 = 16'h0018,
	parameter logic [15:0] VEC_GRP1 = 16'h001C,
	parameter logic [15:0] VEC_GRP2 = 16'h0020,
	parameter logic [15:0] VEC_GRP3 = 16'h0024
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ct0_cmpa_evt,
	input  wire logic        ct0_period_evt,
	input  wire logic        ct1_cmpa_evt,
	input  wire logic        ct1_period_evt,
	input  wire logic        pt_cmpa_evt,
	input  wire logic        pt_period_evt,
	input  wire logic        eeprom_write_done_evt,
	input  wire logic        low_voltage_evt,
	input  wire logic        conv_done_evt,
	input  wire logic [3:0]  ext_irq_pins,
	input  wire logic [3:0]  pin_share_sel,
	input  wire logic [3:0]  port_dir_input,
	input  wire logic [3:0]  pull_high_sel,
	output logic [3:0]       pull_high_en,
	input  wire logic [15:0] next_pc,
	input  wire logic        ret_pop,
	input  wire logic        irq_ack_ready,
	output logic             irq_take,
	output logic [15:0]      irq_vector,
	output logic [15:0]      irq_push_pc,
	output logic [3:0]       stack_ptr,
	output logic             wake_req
);

	mic_pkg::mic_state_s_t s_q;
	mic_pkg::mic_state_s_t s_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// group register update: set beats software clear of a flag
	function automatic logic [7:0] mf_next(input logic [7:0] cur, input logic ea,
		input logic ep, input logic wr, input logic [7:0] wv);
		logic [7:0] r;
		r = wr ? (wv & `MIC_MF_MASK) : cur;
		r[`MIC_B_FLAGA] = r[`MIC_B_FLAGA] | ea;
		r[`MIC_B_FLAGP] = r[`MIC_B_FLAGP] | ep;
		return r;
	endfunction : mf_next

	function automatic logic mf_req(input logic [7:0] r);
		return (r[`MIC_B_FLAGA] & r[`MIC_B_ENA]) | (r[`MIC_B_FLAGP] & r[`MIC_B_ENP]);
	endfunction : mf_req

	function automatic logic edge_hit(input logic [1:0] mode, input logic prev,
		input logic now);
		return (mode[0] & ~prev & now) | (mode[1] & prev & ~now);
	endfunction : edge_hit

	logic [3:0]  pin_act;
	logic [3:0]  pin_edge;
	logic [3:0]  grp_flag;
	logic [3:0]  grp_req;
	logic [8:0]  pend;
	logic        stack_full;
	logic        wr_go;
	logic        rd_go;
	logic        wr_ok;
	logic [3:0]  rd_idx;
	logic [31:0] rd_val;
	logic [7:0]  wv;
	logic [15:0] vec_tab [0:8];

	assign vec_tab[0] = VEC_PIN0;
	assign vec_tab[1] = VEC_PIN1;
	assign vec_tab[2] = VEC_PIN2;
	assign vec_tab[3] = VEC_PIN3;
	assign vec_tab[4] = VEC_CONV;
	assign vec_tab[5] = VEC_GRP0;
	assign vec_tab[6] = VEC_GRP1;
	assign vec_tab[7] = VEC_GRP2;
	assign vec_tab[8] = VEC_GRP3;

	// ----------------------------------------------------------------
	// request network
	// ----------------------------------------------------------------
	always_comb begin
		// pin gating by enable, pin-share and direction
		pin_act = s_q.ctrl[4:1] & pin_share_sel & port_dir_input;
		for (int i = 0; i < 4; i++) begin
			pin_edge[i] = pin_act[i] & edge_hit(s_q.edge_sel[2*i +: 2], s_q.pin_q[i],
				ext_irq_pins[i]);
		end
		grp_flag = {mf_req(s_q.eeprom_lowvolt_irq_ctrl), mf_req(s_q.periodic_timer_irq_ctrl), mf_req(s_q.compact_timer1_irq_ctrl), mf_req(s_q.compact_timer0_irq_ctrl)};
		// group enables sit apart from the pin flags so no bit serves two roles
		grp_req = grp_flag & s_q.ctrl[12:9];
		stack_full = (s_q.sp == `MIC_STACK_DEPTH);
		// pin enable and nonzero edge mode required
		for (int i = 0; i < 4; i++) begin
			pend[i] = s_q.ctrl[5 + i] & s_q.ctrl[1 + i] & (|s_q.edge_sel[2*i +: 2]);
		end
		pend[4] = s_q.ctrl[14] & s_q.ctrl[15];
		// shared group vectors beside own vectors
		pend[8:5] = grp_req;
	end

	// pull-high kept while used as interrupt input
	assign pull_high_en = pull_high_sel;
	assign wake_req = (|s_q.ctrl[8:5]) | s_q.ctrl[14] | (|grp_flag) |
		(|((s_q.compact_timer0_irq_ctrl | s_q.compact_timer1_irq_ctrl | s_q.periodic_timer_irq_ctrl | s_q.eeprom_lowvolt_irq_ctrl) & 8'h30));

	assign irq_take = s_q.ack;
	assign irq_vector = s_q.vec_addr;
	assign irq_push_pc = s_q.push_pc;
	assign stack_ptr = s_q.sp;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	assign s_axi_awready = ~s_q.aw_hold & ~s_q.bvalid;
	assign s_axi_wready  = ~s_q.w_hold & ~s_q.bvalid;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	always_comb begin
		// upper address bits force an unmapped index, so no word aliases
		rd_idx = (|s_axi_araddr[31:6]) ? 4'hF : s_axi_araddr[5:2];
		unique case (rd_idx)
			`MIC_OFS_CT0:  rd_val = {24'h000000, s_q.compact_timer0_irq_ctrl};
			`MIC_OFS_CT1:  rd_val = {24'h000000, s_q.compact_timer1_irq_ctrl};
			`MIC_OFS_PT:   rd_val = {24'h000000, s_q.periodic_timer_irq_ctrl};
			`MIC_OFS_EL:   rd_val = {24'h000000, s_q.eeprom_lowvolt_irq_ctrl};
			`MIC_OFS_EDGE: rd_val = {24'h000000, s_q.edge_sel};
			`MIC_OFS_PRI:  rd_val = {16'h0000, s_q.ctrl};
			`MIC_OFS_STAT: rd_val = {16'h0000, s_q.vec_idx, s_q.sp, 4'h0, grp_flag};
			`MIC_OFS_CORE: rd_val = {16'h0000, s_q.vec_addr};
			default:       rd_val = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		wv = s_q.wdata[7:0];
		wr_go = (s_q.aw_hold | s_axi_awvalid) & (s_q.w_hold | s_axi_wvalid) & ~s_q.bvalid;
		rd_go = s_axi_arvalid & ~s_q.rvalid;
		wr_ok = 1'b0;
		s_d.ack = 1'b0;
		if (s_axi_awvalid & s_axi_awready) begin
			s_d.aw_hold = 1'b1;
			s_d.aw_idx = (|s_axi_awaddr[31:6]) ? 4'hF : s_axi_awaddr[5:2];
		end
		if (s_axi_wvalid & s_axi_wready) begin
			s_d.w_hold = 1'b1;
			s_d.wdata = s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
			wv = s_axi_wdata[7:0];
		end
		if (wr_go) begin
			wr_ok = s_axi_wstrb[0] | s_q.w_hold;
			if (s_q.aw_hold == 1'b0) begin
				s_d.aw_idx = (|s_axi_awaddr[31:6]) ? 4'hF : s_axi_awaddr[5:2];
			end
		end
		s_d.compact_timer0_irq_ctrl = mf_next(s_q.compact_timer0_irq_ctrl, ct0_cmpa_evt, ct0_period_evt,
			wr_ok & (s_d.aw_idx == `MIC_OFS_CT0), wv);
		s_d.compact_timer1_irq_ctrl = mf_next(s_q.compact_timer1_irq_ctrl, ct1_cmpa_evt, ct1_period_evt,
			wr_ok & (s_d.aw_idx == `MIC_OFS_CT1), wv);
		s_d.periodic_timer_irq_ctrl = mf_next(s_q.periodic_timer_irq_ctrl, pt_cmpa_evt, pt_period_evt,
			wr_ok & (s_d.aw_idx == `MIC_OFS_PT), wv);
		s_d.eeprom_lowvolt_irq_ctrl = mf_next(s_q.eeprom_lowvolt_irq_ctrl, eeprom_write_done_evt, low_voltage_evt,
			wr_ok & (s_d.aw_idx == `MIC_OFS_EL), wv);
		if (wr_ok & (s_d.aw_idx == `MIC_OFS_EDGE)) begin
			s_d.edge_sel = wv;
		end
		if (wr_ok & (s_d.aw_idx == `MIC_OFS_PRI)) begin
			s_d.ctrl = s_q.w_hold ? s_q.wdata[15:0] : s_axi_wdata[15:0];
		end
		if (wr_go) begin
			s_d.aw_hold = 1'b0;
			s_d.w_hold = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = (s_d.aw_idx <= `MIC_OFS_CORE) ? 2'b00 : 2'b10;
		end else if (s_q.bvalid & s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val;
			s_d.rresp = (rd_idx <= `MIC_OFS_CORE) ? 2'b00 : 2'b10;
		end else if (s_q.rvalid & s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		s_d.pin_q = ext_irq_pins;
		if (ret_pop & (s_q.sp != 4'h0)) begin
			s_d.sp = s_q.sp - 4'h1;
		end
		unique case (s_q.st)
			mic_pkg::MIC_IDLE: begin
				// accept only with global enable and stack room
				if (s_q.ctrl[0] & (|pend) & ~stack_full & irq_ack_ready) begin
					s_d.st = mic_pkg::MIC_PUSH;
					for (int i = 8; i >= 0; i--) begin
						if (pend[i]) begin
							s_d.vec_idx = 4'(i);
						end
					end
				end
			end
			mic_pkg::MIC_PUSH: begin
				// push next pc and jump to vector
				s_d.ack = 1'b1;
				s_d.push_pc = next_pc;
				s_d.vec_addr = vec_tab[s_q.vec_idx];
				s_d.sp = s_d.sp + 4'h1;
				s_d.ctrl[0] = 1'b0;
				if (s_q.vec_idx < 4'h4) begin
					s_d.ctrl[5 + s_q.vec_idx] = 1'b0;
				end else if (s_q.vec_idx == 4'h4) begin
					s_d.ctrl[14] = 1'b0;
				end
				// group flag is derived; member flags stay for software
				s_d.st = mic_pkg::MIC_DONE;
			end
			mic_pkg::MIC_DONE: begin
				s_d.st = mic_pkg::MIC_IDLE;
			end
			default: begin
				s_d.st = mic_pkg::MIC_IDLE;
			end
		endcase
		// pin flags latch after write and service clear: set wins
		s_d.ctrl[8:5] = s_d.ctrl[8:5] | pin_edge;
		s_d.ctrl[14] = s_d.ctrl[14] | conv_done_evt;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

endmodule : mic_intc
`default_nettype wire

/* File: logic/mic_params.svh */
// Purpose: register offsets, field positions and reset values of the interrupt controller
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// ----------------------------------------------------------------
// register word indices (byte address bits 5:2)
// ----------------------------------------------------------------
`define MIC_OFS_CT0       4'h0
`define MIC_OFS_CT1       4'h1
`define MIC_OFS_PT        4'h2
`define MIC_OFS_EL        4'h3
`define MIC_OFS_EDGE      4'h4
`define MIC_OFS_PRI       4'h5
`define MIC_OFS_STAT      4'h6
`define MIC_OFS_CORE      4'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MIC_B_FLAGA       5
`define MIC_B_FLAGP       4
`define MIC_B_ENA         1
`define MIC_B_ENP         0
`define MIC_MF_MASK       8'h33
`define MIC_RST8          8'h00
`define MIC_RST16         16'h0000
`define MIC_STACK_DEPTH   4'h8

`endif

/* File: logic/mic_pkg.sv */
// Purpose: types of the interrupt controller
// Assumes: constants come from mic_params.svh
// Notes:   vector index order is the fixed priority order, 0 highest
package mic_pkg;

	typedef enum logic [1:0] {
		MIC_IDLE  = 2'b00,
		MIC_PUSH  = 2'b01,
		MIC_DONE  = 2'b11
	} mic_state_t;

	typedef struct packed {
		mic_state_t  st;
		logic [7:0]  compact_timer0_irq_ctrl;
		logic [7:0]  compact_timer1_irq_ctrl;
		logic [7:0]  periodic_timer_irq_ctrl;
		logic [7:0]  eeprom_lowvolt_irq_ctrl;
		logic [7:0]  edge_sel;
		logic [15:0] ctrl;
		logic [3:0]  pin_q;
		logic [3:0]  sp;
		logic        ack;
		logic [3:0]  vec_idx;
		logic [15:0] vec_addr;
		logic [15:0] push_pc;
		logic        aw_hold;
		logic        w_hold;
		logic [3:0]  aw_idx;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mic_state_s_t;

endpackage : mic_pkg
